// [mulp_pipe.sv]
// Purpose: Output pipeline of configurable depth with enable and two clears.
// Assumes: Depth zero means a plain wire from input to output.
// Notes:   Synchronous clear wins over a low enable.
module mulp_pipe #(
    parameter int WIDTH   = 32,
    parameter int LATENCY = 0
) (
    input  wire logic             clk,     // Pipeline clock
    input  wire logic             rst_n,   // Asynchronous reset, active low
    input  wire logic             aclr,    // Asynchronous clear, active high
    input  wire logic             en,      // Advance enable
    input  wire logic             sclr,    // Synchronous clear
    input  wire logic [WIDTH-1:0] din,     // Stage input
    output logic      [WIDTH-1:0] dout     // Last stage output
);
    import mulp_pkg::*;

    if (LATENCY == 0) begin : g_comb
        assign dout = din;
    end else begin : g_pipe
        logic [WIDTH-1:0] chain [LATENCY+1];
        assign chain[0] = din;
        for (genvar g = 0; g < LATENCY; g++) begin : g_stage
            logic [WIDTH-1:0] stg_reg;
            logic [WIDTH-1:0] stg_next;
            always_comb begin
                if (sclr) begin
                    stg_next = '0;
                end else if (en) begin
                    stg_next = chain[g];
                end else begin
                    stg_next = stg_reg;
                end
            end
            always_ff @(posedge clk or negedge rst_n or posedge aclr) begin
                if (!rst_n || aclr) begin
                    stg_reg <= '0;
                end else begin
                    stg_reg <= stg_next;
                end
            end
            assign chain[g+1] = stg_reg;

            AST_STAGE_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n || aclr)
                (en && !sclr) |=> (stg_reg == $past(chain[g])))
                else $error("Pipeline stage did not take its input");
        end
        assign dout = chain[LATENCY];
    end
endmodule

// [mulp_pkg.sv]
// Purpose: Shared constants and types for the pipelined integer multiplier.
// Assumes: One clock (pclk); registers reached over APB with 32-bit data.
// Notes:   Register offsets are byte addresses; each register is one aligned word.
//
// Notes on behaviour
// - Two operands, each with its own width parameter; output is their product.
// - Each operand width may be anything from 1 to 256 bits.
// - Second operand may be a fixed constant chosen at build time.
// - Operands are both unsigned or both two's complement, chosen at build time.
// - Optional output pipeline of N cycles, default zero; N>0 needs running clock.
// - Clock enable high advances the pipeline while the run bit is set, low holds it; unconnected means 1.
// - Asynchronous clear zeroes every pipeline stage at once, without a clock edge.
// - Synchronous clear zeroes every pipeline stage at the next clock edge.
// - A result narrower than the full product keeps only the top bits.
package mulp_pkg;

    typedef enum logic {
        MULP_UNSIGNED = 1'b0,
        MULP_SIGNED   = 1'b1
    } mulp_sign_t;

    localparam int WIDTH_MIN       = 1;
    localparam int WIDTH_MAX       = 256;
    localparam int DEF_A_WIDTH     = 16;
    localparam int DEF_B_WIDTH     = 16;
    localparam int DEF_LATENCY     = 0;

    localparam int APB_AW          = 8;
    localparam int APB_DW          = 32;

    localparam logic [APB_AW-1:0] OFS_CTRL      = 8'h00;
    localparam logic [APB_AW-1:0] OFS_STATUS    = 8'h04;
    localparam logic [APB_AW-1:0] OFS_RESULT_LO = 8'h08;

    localparam int CTRL_RUN_BIT    = 0;
    localparam int CTRL_CLEAR_BIT  = 1;
    localparam int STAT_ENABLE_BIT = 0;
    localparam int STAT_CLEAR_BIT  = 1;

    localparam logic CTRL_RUN_RESET = 1'b1;

endpackage

// [mulp_top.sv]
// Purpose: Parameterised integer multiplier with output pipeline and APB control.
// Assumes: Operands and clears come from logic on pclk; no pin synchronisers.
// Notes:   With zero latency the result is combinational from the operands.
//
// The APB register port and the placing of the registers are this design's own decisions.
module mulp_top #(
    parameter int                   OPERAND_A_WIDTH = mulp_pkg::DEF_A_WIDTH,
    parameter int                   OPERAND_B_WIDTH = mulp_pkg::DEF_B_WIDTH,
    parameter int                   PRODUCT_WIDTH   = OPERAND_A_WIDTH + OPERAND_B_WIDTH,
    parameter mulp_pkg::mulp_sign_t SIGN_MODE       = mulp_pkg::MULP_UNSIGNED,
    parameter bit                   CONST_B_EN      = 1'b0,
    parameter logic [OPERAND_B_WIDTH-1:0] CONST_B_VALUE = '0,
    parameter int                   LATENCY         = mulp_pkg::DEF_LATENCY
) (
    input  wire logic                        pclk,       // Clock, 125 MHz
    input  wire logic                        presetn,    // Async reset, active low
    input  wire logic [mulp_pkg::APB_AW-1:0] paddr,      // APB byte address
    input  wire logic                        psel,       // APB select
    input  wire logic                        penable,    // APB access phase
    input  wire logic                        pwrite,     // APB write
    input  wire logic [mulp_pkg::APB_DW-1:0] pwdata,     // APB write data
    output logic      [mulp_pkg::APB_DW-1:0] prdata,     // APB read data
    output logic                             pready,     // APB ready
    output logic                             pslverr,    // APB error
    input  wire logic [OPERAND_A_WIDTH-1:0]  operand_a,  // First operand
    input  wire logic [OPERAND_B_WIDTH-1:0]  operand_b,  // Second operand
    input  wire logic                        clken = 1'b1, // Pipeline enable
    input  wire logic                        aclr,       // Async clear, high
    input  wire logic                        sclr,       // Sync clear, high
    output logic      [PRODUCT_WIDTH-1:0]    result      // Product
);
    import mulp_pkg::*;

    localparam int FULL_W = OPERAND_A_WIDTH + OPERAND_B_WIDTH;

    if (OPERAND_A_WIDTH < WIDTH_MIN || OPERAND_A_WIDTH > WIDTH_MAX ||
        OPERAND_B_WIDTH < WIDTH_MIN || OPERAND_B_WIDTH > WIDTH_MAX) begin : g_bad_width
        $error("Operand width outside 1 to 256");
    end

    // Operand selection and product
    logic [OPERAND_B_WIDTH-1:0] b_used;
    logic                       sgn;
    logic signed [OPERAND_A_WIDTH:0]   a_ext;
    logic signed [OPERAND_B_WIDTH:0]   b_ext;
    logic signed [FULL_W+1:0]          prod_ext;
    logic [FULL_W-1:0]                 full_prod;
    logic [PRODUCT_WIDTH-1:0]          trunc_prod;

    assign b_used = CONST_B_EN ? CONST_B_VALUE : operand_b;
    assign sgn    = (SIGN_MODE == MULP_SIGNED);

    // One extra bit per operand lets a single signed multiply serve both modes
    always_comb begin
        a_ext    = $signed({sgn & operand_a[OPERAND_A_WIDTH-1], operand_a});
        b_ext    = $signed({sgn & b_used[OPERAND_B_WIDTH-1], b_used});
        prod_ext = (FULL_W+2)'(a_ext) * (FULL_W+2)'(b_ext);
        full_prod = prod_ext[FULL_W-1:0];
    end

    if (PRODUCT_WIDTH <= FULL_W) begin : g_trunc
        assign trunc_prod = full_prod[FULL_W-1 -: PRODUCT_WIDTH];
    end else begin : g_wide
        assign trunc_prod = {{(PRODUCT_WIDTH-FULL_W){sgn & full_prod[FULL_W-1]}}, full_prod};
    end

    // Control register and pipeline qualifiers
    logic ctrl_run_reg;
    logic ctrl_run_next;
    logic soft_clr_reg;
    logic soft_clr_next;
    logic pipe_en;
    logic pipe_sclr;

    assign pipe_en   = clken & ctrl_run_reg;
    assign pipe_sclr = sclr | soft_clr_reg;

    mulp_pipe #(
        .WIDTH   (PRODUCT_WIDTH),
        .LATENCY (LATENCY)
    ) u_pipe (
        .clk   (pclk),
        .rst_n (presetn),
        .aclr  (aclr),
        .en    (pipe_en),
        .sclr  (pipe_sclr),
        .din   (trunc_prod),
        .dout  (result)
    );

    // APB slave: one wait state, answer registered
    logic              acc;
    logic              wr_done;
    logic              mapped;
    logic [APB_DW-1:0] rd_word;
    logic [APB_DW-1:0] res_word;
    logic [APB_DW-1:0] prdata_next;
    logic              pready_next;
    logic              pslverr_next;

    assign acc     = psel & penable;
    assign wr_done = acc & pready & pwrite & ~pslverr;

    always_comb begin
        res_word = '0;
        for (int i = 0; i < APB_DW; i++) begin
            if (i < PRODUCT_WIDTH) begin
                res_word[i] = result[i];
            end
        end
    end

    always_comb begin
        rd_word = '0;
        mapped  = 1'b1;
        unique case ({paddr[APB_AW-1:2], 2'b00})
            OFS_CTRL: begin
                rd_word[CTRL_RUN_BIT] = ctrl_run_reg;
            end
            OFS_STATUS: begin
                rd_word[STAT_ENABLE_BIT] = pipe_en;
                rd_word[STAT_CLEAR_BIT]  = aclr | pipe_sclr;
            end
            OFS_RESULT_LO: begin
                rd_word = res_word;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        pready_next  = acc & ~pready;
        pslverr_next = acc & ~pready & ~mapped;
        prdata_next  = prdata;
        if (acc && !pready) begin
            prdata_next = (mapped && !pwrite) ? rd_word : '0;
        end
    end

    // Clear bit is write-one, self-clearing after one cycle
    always_comb begin
        ctrl_run_next = ctrl_run_reg;
        soft_clr_next = 1'b0;
        if (wr_done && {paddr[APB_AW-1:2], 2'b00} == OFS_CTRL) begin
            ctrl_run_next = pwdata[CTRL_RUN_BIT];
            soft_clr_next = pwdata[CTRL_CLEAR_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata       <= '0;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            ctrl_run_reg <= CTRL_RUN_RESET;
            soft_clr_reg <= 1'b0;
        end else begin
            prdata       <= prdata_next;
            pready       <= pready_next;
            pslverr      <= pslverr_next;
            ctrl_run_reg <= ctrl_run_next;
            soft_clr_reg <= soft_clr_next;
        end
    end

    // Checks
    logic [FULL_W-1:0] ref_prod;
    logic [FULL_W-1:0] ref_const;
    always_comb begin
        if (SIGN_MODE == MULP_SIGNED) begin
            ref_prod  = FULL_W'($signed(operand_a)) * FULL_W'($signed(b_used));
            ref_const = FULL_W'($signed(operand_a)) * FULL_W'($signed(CONST_B_VALUE));
        end else begin
            ref_prod  = FULL_W'(operand_a) * FULL_W'(b_used);
            ref_const = FULL_W'(operand_a) * FULL_W'(CONST_B_VALUE);
        end
    end

    AST_FULL_PRODUCT: assert property (@(posedge pclk) disable iff (!presetn)
        full_prod == ref_prod)
        else $error("Full product differs from reference");

    AST_SIGN_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        (sgn && (operand_a[OPERAND_A_WIDTH-1] ^ b_used[OPERAND_B_WIDTH-1]) &&
         operand_a != '0 && b_used != '0)
        |-> full_prod[FULL_W-1])
        else $error("Signed product of mixed signs is not negative");

    AST_WIDTH_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        OPERAND_A_WIDTH inside {[WIDTH_MIN:WIDTH_MAX]} &&
        OPERAND_B_WIDTH inside {[WIDTH_MIN:WIDTH_MAX]})
        else $error("Operand width out of range");

    AST_CONST_B: assert property (@(posedge pclk) disable iff (!presetn)
        CONST_B_EN |-> (full_prod == ref_const))
        else $error("Constant second operand not applied");

    AST_TRUNCATE: assert property (@(posedge pclk) disable iff (!presetn)
        (PRODUCT_WIDTH <= FULL_W) |->
        (trunc_prod == PRODUCT_WIDTH'(ref_prod >> (FULL_W - PRODUCT_WIDTH))))
        else $error("Result does not hold top product bits");

    AST_AUTO_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
        (PRODUCT_WIDTH == FULL_W) |-> (trunc_prod == ref_prod))
        else $error("Automatic width result is not the full product");

    if (LATENCY > 0) begin : g_pipe_checks
        // Ones mark edges at which every stage advanced; all ones means a clean path
        logic [LATENCY-1:0] adv_hist_reg;
        logic [LATENCY-1:0] adv_hist_next;

        always_comb begin
            adv_hist_next = LATENCY'({adv_hist_reg, pipe_en & ~pipe_sclr});
        end

        always_ff @(posedge pclk or negedge presetn or posedge aclr) begin
            if (!presetn || aclr) begin
                adv_hist_reg <= '0;
            end else begin
                adv_hist_reg <= adv_hist_next;
            end
        end

        AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn || aclr)
            (!pipe_en && !pipe_sclr) |=> $stable(result))
            else $error("Result moved while disabled");

        AST_SYNC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn || aclr)
            pipe_sclr |=> (result == '0))
            else $error("Synchronous clear did not zero result");

        AST_ASYNC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
            aclr |-> (result == '0))
            else $error("Asynchronous clear did not zero result");

        AST_LATENCY_PATH: assert property (@(posedge pclk) disable iff (!presetn || aclr)
            (&adv_hist_reg) |-> (result == $past(trunc_prod, LATENCY)))
            else $error("Pipeline output is not the delayed product");
    end else begin : g_comb_checks
        AST_ZERO_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
            result == trunc_prod)
            else $error("Zero latency result not combinational");
    end

    AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && !pready) |=> (pready ##1 !pready))
        else $error("APB answer not one cycle after access");

    AST_CTRL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && {paddr[APB_AW-1:2], 2'b00} == OFS_CTRL)
        |=> (ctrl_run_reg == $past(pwdata[CTRL_RUN_BIT])))
        else $error("Run bit not written");

    COV_SIGNED_NEG: cover property (@(posedge pclk) disable iff (!presetn)
        sgn && full_prod[FULL_W-1]);
    COV_HOLD: cover property (@(posedge pclk) disable iff (!presetn)
        !pipe_en ##1 !pipe_en ##1 pipe_en);
    COV_SCLR: cover property (@(posedge pclk) disable iff (!presetn) pipe_sclr);
    COV_APB_ERR: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule

// [mulp_user_src.sv]
// Purpose: Model of the user logic that feeds operands to the multiplier.
// Assumes: Same clock as the multiplier; operands launched from flops.
// Notes:   One cycle from request to operand, like any registered source.
module mulp_user_src #(
    parameter int AW = 8,
    parameter int BW = 8
) (
    input  wire logic          pclk,      // Shared running clock
    input  wire logic [AW-1:0] a_in,      // Requested first operand
    input  wire logic [BW-1:0] b_in,      // Requested second operand
    output logic      [AW-1:0] operand_a, // First operand to multiplier
    output logic      [BW-1:0] operand_b  // Second operand to multiplier
);
    timeunit 1ns;
    timeprecision 1ps;

    // Launched on the edge so the multiplier never sees a mid-cycle change
    always_ff @(posedge pclk) begin
        operand_a <= a_in;
        operand_b <= b_in;
    end
endmodule

// [test_pipelined_integer_multiplier.sv]
// Purpose: Self-checking bench for the multiplier, APB control and pipeline.
// Assumes: Two instances share stimulus: unsigned full-width, signed truncated.
// Notes:   Second instance multiplies by a constant, so its operand_b is ignored.
module test_pipelined_integer_multiplier;
    timeunit 1ns;
    timeprecision 1ps;
    import mulp_pkg::*;
    localparam int         OP_W = 8;
    localparam int         LAT  = 2;
    localparam logic [7:0] K_B  = 8'hfd;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              clken, aclr, sclr;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, rd;
    logic [7:0]        a_nxt, b_nxt, operand_a, operand_b, result_s;
    logic [15:0]       result, last;
    logic signed [15:0] ps;
    logic              er;
    int                fail_count, num_checks;
    logic [7:0]        av [4] = '{8'hff, 8'h80, 8'h01, 8'h7f};
    logic [7:0]        bv [4] = '{8'hff, 8'h02, 8'h00, 8'h81};

    mulp_user_src #(.AW(OP_W), .BW(OP_W)) mulp_user_src_i (.pclk(pclk), .a_in(a_nxt),
        .b_in(b_nxt), .operand_a(operand_a), .operand_b(operand_b));
    mulp_top #(.OPERAND_A_WIDTH(OP_W), .OPERAND_B_WIDTH(OP_W), .LATENCY(LAT)) mulp_top_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .operand_a(operand_a), .operand_b(operand_b), .clken(clken),
        .aclr(aclr), .sclr(sclr), .result(result));
    // Constant of minus three exercises sign handling of the fixed operand
    mulp_top #(.OPERAND_A_WIDTH(OP_W), .OPERAND_B_WIDTH(OP_W), .PRODUCT_WIDTH(OP_W),
        .SIGN_MODE(MULP_SIGNED), .CONST_B_EN(1'b1), .CONST_B_VALUE(K_B)) mulp_top_sgn_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .operand_a(operand_a), .operand_b(operand_b), .clken(clken), .aclr(aclr),
        .sclr(sclr), .result(result_s));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check_res(string nm, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One whole transfer; ends one edge late so the next setup never collides
    task automatic apb(logic wr, logic [7:0] ad, logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic check_reg(string nm, logic [7:0] ad, logic [31:0] exp, logic exp_er);
        apb(1'b0, ad, 32'h0);
        num_checks += 2;
        if (rd !== exp || er !== exp_er) begin
            fail_count++;
            $display("MISMATCH %s expected %h/%b seen %h/%b", nm, exp, exp_er, rd, er);
        end
    endtask

    task automatic feed(logic [7:0] a, logic [7:0] b);
        a_nxt <= a;
        b_nxt <= b;
        repeat (4) @(posedge pclk);
    endtask

    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end

    initial begin
        {presetn, psel, penable, pwrite, aclr, sclr} = '0;
        clken = 1'b1;
        paddr = '0;
        pwdata = '0;
        a_nxt = '0;
        b_nxt = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_reg("ctrl", OFS_CTRL, 32'h1, 1'b0);
        check_reg("status", OFS_STATUS, 32'h1, 1'b0);
        check_reg("unmapped", 8'h0c, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            feed(av[i], bv[i]);
            last = {8'h0, av[i]} * {8'h0, bv[i]};
            ps = $signed(av[i]);
            ps = ps * -16'sd3;
            check_res("product", last, result);
            check_res("signed_top", {8'h0, ps[15:8]}, {8'h0, result_s});
        end
        check_reg("result_lo", OFS_RESULT_LO, {16'h0, last}, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h0);
        feed(8'h03, 8'h05);
        check_res("run_hold", last, result);
        check_reg("status_off", OFS_STATUS, 32'h0, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        check_res("run_go", 16'h000f, result);
        clken <= 1'b0;
        feed(8'h07, 8'h09);
        check_res("clken_hold", 16'h000f, result);
        clken <= 1'b1;
        repeat (3) @(posedge pclk);
        check_res("clken_go", 16'h003f, result);
        sclr <= 1'b1;
        @(posedge pclk);
        sclr <= 1'b0;
        #1 check_res("sync_clear", 16'h0, result);
        repeat (3) @(posedge pclk);
        check_res("refill", 16'h003f, result);
        apb(1'b1, OFS_CTRL, 32'h3);
        #1 check_res("soft_clear", 16'h0, result);
        repeat (3) @(posedge pclk);
        check_res("soft_refill", 16'h003f, result);
        aclr <= 1'b1;
        #1 check_res("async_clear", 16'h0, result);
        @(posedge pclk);
        check_reg("status_clr", OFS_STATUS, 32'h3, 1'b0);
        aclr <= 1'b0;
        repeat (3) @(posedge pclk);
        check_res("after_clear", 16'h003f, result);
        give_verdict();
    end
endmodule
